//--- verilog/dplcfg_top.sv
// Purpose: serial configuration port, lock detectors, reference dividers, pump controls
// Assumes: all pins synchronous to ref_clk_i; edges arrive as one-cycle pulses
// Notes: phase error arrives as a measured magnitude in ps with a compare strobe
`timescale 1ns/1ns
module dplcfg_top #(
  parameter int PHASE_W = 16
) (
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         cfg_clk_i,
  input  wire logic                         cfg_data_i,
  input  wire logic                         cfg_latch_i,
  input  wire logic                         clean_cmp_i,
  input  wire logic [PHASE_W-1:0]           clean_phase_err_i,
  input  wire logic                         synth_cmp_i,
  input  wire logic [PHASE_W-1:0]           synth_phase_err_i,
  input  wire logic [2:0]                   input_edge_i,
  input  wire logic [1:0]                   active_input_i,
  input  wire logic                         osc_rise_i,
  input  wire logic                         osc_fall_i,
  output      logic                         cleaning_lock_o,
  output      logic                         synthesis_lock_o,
  output      logic                         cleaning_pd_ref_o,
  output      logic                         synthesis_pd_ref_o,
  output      logic [dplcfg_pkg::UA_W-1:0]  cleaning_pump_current_o,
  output      logic                         cleaning_pump_hiz_o,
  output      logic                         cleaning_pump_polarity_o,
  output      logic [dplcfg_pkg::UA_W-1:0]  synthesis_pump_current_o,
  output      logic                         synthesis_pump_hiz_o,
  output      logic                         synthesis_pump_polarity_o,
  output      logic                         ref_doubler_enable_o
);
  import dplcfg_pkg::*;

  // refused at elaboration: a narrower error bus cannot hold the widest window
  if (PHASE_W < PS_W) begin : g_phase_w_check
    $error("PHASE_W must hold the widest window");
  end

  // configuration state
  logic [WORD_W-1:0] shift_reg, shift_next;
  logic              sclk_d_reg, sclk_d_next;
  logic              latch_d_reg, latch_d_next;
  logic [WORD_W-1:0] cwin_reg, cwin_next;
  logic [WORD_W-1:0] lcnt_reg, lcnt_next;
  logic [WORD_W-1:0] scfg_reg, scfg_next;
  logic [WORD_W-1:0] ccfg_reg, ccfg_next;
  logic [WORD_W-1:0] srdiv_reg, srdiv_next;
  logic              shift_en;
  logic              write_en;

  assign shift_en = cfg_clk_i && !sclk_d_reg && !cfg_latch_i;
  assign write_en = cfg_latch_i && !latch_d_reg;

  always_comb begin
    sclk_d_next  = cfg_clk_i;
    latch_d_next = cfg_latch_i;
    shift_next   = shift_en ? {shift_reg[WORD_W-2:0], cfg_data_i} : shift_reg;
    cwin_next    = cwin_reg;
    lcnt_next    = lcnt_reg;
    scfg_next    = scfg_reg;
    ccfg_next    = ccfg_reg;
    srdiv_next   = srdiv_reg;
    if (write_en) begin
      // address bits read back as zero in the stored copy
      case (shift_reg[ADDR_W-1:0])
        ADDR_CLEAN_WIN:  cwin_next  = {shift_reg[WORD_W-1:ADDR_W], 5'h00};
        ADDR_LOCK_COUNT: lcnt_next  = {shift_reg[WORD_W-1:ADDR_W], 5'h00};
        ADDR_SYNTH_CFG:  scfg_next  = {shift_reg[WORD_W-1:ADDR_W], 5'h00};
        ADDR_CLEAN_CFG:  ccfg_next  = {shift_reg[WORD_W-1:ADDR_W], 5'h00};
        ADDR_SYNTH_RDIV: srdiv_next = {shift_reg[WORD_W-1:ADDR_W], 5'h00};
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      shift_reg   <= '0;
      sclk_d_reg  <= 1'b0;
      latch_d_reg <= 1'b0;
      cwin_reg    <= RST_CLEAN_WIN;
      lcnt_reg    <= RST_LOCK_COUNT;
      scfg_reg    <= RST_SYNTH_CFG;
      ccfg_reg    <= RST_CLEAN_CFG;
      srdiv_reg   <= RST_SYNTH_RDIV;
    end else begin
      shift_reg   <= shift_next;
      sclk_d_reg  <= sclk_d_next;
      latch_d_reg <= latch_d_next;
      cwin_reg    <= cwin_next;
      lcnt_reg    <= lcnt_next;
      scfg_reg    <= scfg_next;
      ccfg_reg    <= ccfg_next;
      srdiv_reg   <= srdiv_next;
    end
  end

  // field views
  logic [1:0]         clean_win_code, synth_win_code, sgain, cgain, pre_code;
  logic [CNT_W-1:0]   clean_tgt, synth_tgt, crdiv;
  logic [SRDIV_W-1:0] srdiv;
  logic               sdbl, shiz, chiz;
  assign clean_win_code = cwin_reg[CLEAN_WIN_LSB +: 2];
  assign clean_tgt      = lcnt_reg[COUNT_LSB +: CNT_W];
  assign synth_win_code = scfg_reg[SWIN_LSB +: 2];
  assign synth_tgt      = scfg_reg[COUNT_LSB +: CNT_W];
  assign sdbl           = scfg_reg[DOUBLER_BIT];
  assign sgain          = scfg_reg[GAIN_LSB +: 2];
  assign shiz           = scfg_reg[HIZ_BIT];
  assign cgain          = ccfg_reg[GAIN_LSB +: 2];
  assign chiz           = ccfg_reg[HIZ_BIT];
  assign crdiv          = ccfg_reg[CRDIV_LSB +: CNT_W];
  assign srdiv          = srdiv_reg[SRDIV_LSB +: SRDIV_W];

  // lock detectors: result is {lock, count}
  function automatic logic [CNT_W:0] lock_step(input logic cmp, input logic in_win,
      input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] tgt, input logic lk);
    logic [CNT_W-1:0] c;
    c = cnt;
    if (!cmp) begin
      lock_step = {lk, cnt};
    end else if (!in_win) begin
      lock_step = '0;
    end else begin
      if (cnt != {CNT_W{1'b1}}) c = cnt + 1'b1;
      lock_step = {(tgt != '0) && (c >= tgt), c};
    end
  endfunction : lock_step

  logic [CNT_W-1:0] ccnt_reg, ccnt_next, scnt_reg, scnt_next;
  logic             clock_reg, clock_next, slock_reg, slock_next;
  logic             clean_in_win, synth_in_win;

  assign clean_in_win = clean_phase_err_i < PHASE_W'(CLEAN_WIN_PS[clean_win_code]);
  // reserved window codes never count as in window
  assign synth_in_win = (synth_win_code == SWIN_VALID) &&
                        (synth_phase_err_i < PHASE_W'(SYNTH_WIN_PS));

  always_comb begin
    {clock_next, ccnt_next} = lock_step(clean_cmp_i, clean_in_win, ccnt_reg,
                                        clean_tgt, clock_reg);
    {slock_next, scnt_next} = lock_step(synth_cmp_i, synth_in_win, scnt_reg,
                                        synth_tgt, slock_reg);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ccnt_reg  <= '0;
      scnt_reg  <= '0;
      clock_reg <= 1'b0;
      slock_reg <= 1'b0;
    end else begin
      ccnt_reg  <= ccnt_next;
      scnt_reg  <= scnt_next;
      clock_reg <= clock_next;
      slock_reg <= slock_next;
    end
  end

  // reference dividers
  logic [2:0]         pre_cnt_reg, pre_cnt_next;
  logic [1:0]         act_d_reg, act_d_next;
  logic [CNT_W-1:0]   crcnt_reg, crcnt_next;
  logic [SRDIV_W-1:0] srcnt_reg, srcnt_next;
  logic               cref_reg, cref_next, sref_reg, sref_next;
  logic               pre_tick, sel_edge, osc_edge;

  always_comb begin
    case (active_input_i)
      2'h0:    pre_code = ccfg_reg[PRE0_LSB +: 2];
      2'h1:    pre_code = ccfg_reg[PRE1_LSB +: 2];
      2'h2:    pre_code = ccfg_reg[PRE2_LSB +: 2];
      default: pre_code = ccfg_reg[PRE0_LSB +: 2];
    endcase
  end

  // input 3 does not exist; an out-of-range select is steered to input 0
  assign sel_edge = (active_input_i == 2'h3) ? input_edge_i[0] : input_edge_i[active_input_i];
  assign osc_edge = osc_rise_i || (sdbl && osc_fall_i);

  always_comb begin
    pre_cnt_next = pre_cnt_reg;
    pre_tick     = 1'b0;
    act_d_next   = active_input_i;
    crcnt_next   = crcnt_reg;
    cref_next    = 1'b0;
    srcnt_next   = srcnt_reg;
    sref_next    = 1'b0;
    if (active_input_i != act_d_reg) begin
      pre_cnt_next = '0;
    end else if (sel_edge) begin
      if ({1'b0, pre_cnt_reg} + 4'h1 >= (4'h1 << pre_code)) begin
        pre_cnt_next = '0;
        pre_tick     = 1'b1;
      end else begin
        pre_cnt_next = pre_cnt_reg + 3'h1;
      end
    end
    if (pre_tick && crdiv != '0) begin
      if ({1'b0, crcnt_reg} + 15'h1 >= {1'b0, crdiv}) begin
        crcnt_next = '0;
        cref_next  = 1'b1;
      end else begin
        crcnt_next = crcnt_reg + 14'h1;
      end
    end
    // a divide of 1 without the doubler is the host's to avoid
    if (osc_edge && srdiv != '0) begin
      if ({1'b0, srcnt_reg} + 13'h1 >= {1'b0, srdiv}) begin
        srcnt_next = '0;
        sref_next  = 1'b1;
      end else begin
        srcnt_next = srcnt_reg + 12'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pre_cnt_reg <= '0;
      act_d_reg   <= '0;
      crcnt_reg   <= '0;
      srcnt_reg   <= '0;
      cref_reg    <= 1'b0;
      sref_reg    <= 1'b0;
    end else begin
      pre_cnt_reg <= pre_cnt_next;
      act_d_reg   <= act_d_next;
      crcnt_reg   <= crcnt_next;
      srcnt_reg   <= srcnt_next;
      cref_reg    <= cref_next;
      sref_reg    <= sref_next;
    end
  end

  // pump controls
  logic [UA_W-1:0] cua_reg, cua_next, sua_reg, sua_next;
  logic            chiz_reg, chiz_next, shiz_reg, shiz_next;
  logic            cpol_reg, cpol_next, spol_reg, spol_next, dbl_reg, dbl_next;

  always_comb begin
    cua_next  = chiz ? '0 : CLEAN_UA[cgain];
    sua_next  = shiz ? '0 : SYNTH_UA[sgain];
    chiz_next = chiz;
    shiz_next = shiz;
    cpol_next = ccfg_reg[POL_BIT];
    spol_next = scfg_reg[POL_BIT];
    dbl_next  = sdbl;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cua_reg  <= '0;
      sua_reg  <= '0;
      chiz_reg <= 1'b1;
      shiz_reg <= 1'b1;
      cpol_reg <= 1'b0;
      spol_reg <= 1'b0;
      dbl_reg  <= 1'b0;
    end else begin
      cua_reg  <= cua_next;
      sua_reg  <= sua_next;
      chiz_reg <= chiz_next;
      shiz_reg <= shiz_next;
      cpol_reg <= cpol_next;
      spol_reg <= spol_next;
      dbl_reg  <= dbl_next;
    end
  end

  assign cleaning_lock_o           = clock_reg;
  assign synthesis_lock_o          = slock_reg;
  assign cleaning_pd_ref_o         = cref_reg;
  assign synthesis_pd_ref_o        = sref_reg;
  assign cleaning_pump_current_o   = cua_reg;
  assign cleaning_pump_hiz_o       = chiz_reg;
  assign cleaning_pump_polarity_o  = cpol_reg;
  assign synthesis_pump_current_o  = sua_reg;
  assign synthesis_pump_hiz_o      = shiz_reg;
  assign synthesis_pump_polarity_o = spol_reg;
  assign ref_doubler_enable_o      = dbl_reg;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  AST_CLEAN_LOCK_COUNT: assert property ($rose(clock_reg) |->
    clean_tgt != '0 && ccnt_reg >= clean_tgt) else $error("cleaning lock before count");
  AST_CLEAN_WIDE_OUT: assert property (clean_cmp_i && clean_phase_err_i >= 16'h9C40
    |=> !clock_reg) else $error("cleaning lock kept beyond widest window");
  AST_SYNTH_INC: assert property (synth_cmp_i && synth_in_win &&
    scnt_reg != 14'h3FFF |=> scnt_reg == $past(scnt_reg) + 14'h1)
    else $error("synthesis counter did not step");
  AST_SYNTH_LOCK_COUNT: assert property ($rose(slock_reg) |->
    synth_tgt != '0 && scnt_reg >= synth_tgt) else $error("synthesis lock before count");
  AST_OUT_CLEARS: assert property (clean_cmp_i && !clean_in_win |=>
    ccnt_reg == '0 && !clock_reg) else $error("counter not cleared on miss");
  AST_NO_DOUBLE: assert property (!sdbl && !osc_rise_i && osc_fall_i |=>
    srcnt_reg == $past(srcnt_reg) && !sref_reg) else $error("falling edge counted");
  AST_SPOL: assert property (##1 spol_reg == $past(scfg_reg[POL_BIT]))
    else $error("synthesis polarity mismatch");
  AST_SHIZ: assert property (shiz |=> synthesis_pump_hiz_o &&
    synthesis_pump_current_o == '0) else $error("synthesis pump not high impedance");
  AST_SCUR: assert property (!shiz && sgain == 2'h3 |=>
    synthesis_pump_current_o == 12'hC80) else $error("synthesis current wrong");
  AST_CCUR: assert property (!chiz && cgain == 2'h1 |=>
    cleaning_pump_current_o == 12'h0C8) else $error("cleaning current wrong");
  AST_SWITCH: assert property (active_input_i != act_d_reg |=>
    pre_cnt_reg == '0) else $error("pre-divider not restarted on switch");
  AST_CZERO: assert property (crdiv == '0 |=> !cref_reg)
    else $error("cleaning reference out with zero divide");
  AST_SZERO: assert property (srdiv == '0 |=> !sref_reg)
    else $error("synthesis reference out with zero divide");
endmodule : dplcfg_top

//--- verilog/dplcfg_pkg.sv
// Purpose: constants for the dual-loop lock-detect and divider configuration block
// Assumes: 32-bit serial words, address in bits [4:0], data in bits [31:5]
// Notes: window times are in picoseconds, currents in microamps
//
// Behaviour
// - cleaning lock asserts after programmed count of in-window comparisons; zero count never locks.
// - cleaning window codes 0..3 select 5.5, 10, 18.6, 40 ns windows.
// - synthesis lock counter increments on each comparison below the window time.
// - synthesis lock asserts after programmed 14-bit count; zero count never locks.
// - doubler enable 1 counts both reference edges, 0 counts rising only.
// - synthesis polarity 0 negative slope, 1 positive; host picks negative for internal oscillator.
// - synthesis pump current codes select 100, 400, 1600, 3200 uA.
// - synthesis pump high-impedance bit overrides current field.
// - cleaning polarity 0 negative slope, 1 positive slope.
// - cleaning pump current codes select 100, 200, 400, 1600 uA.
// - cleaning pump high-impedance bit overrides current field.
// - each of three inputs has 2-bit pre-divider by 1, 2, 4, 8.
// - input switch applies the new input's pre-divider at once.
// - cleaning reference divider divides by 1..16383; zero gives no output.
// - synthesis reference divider divides by 1..4095; zero gives no output.
package dplcfg_pkg;
  localparam int          WORD_W          = 32;
  localparam int          ADDR_W          = 5;
  localparam int          CNT_W           = 14;
  localparam int          SRDIV_W         = 12;
  localparam int          UA_W            = 12;
  localparam int          PS_W            = 16;
  localparam logic [4:0]  ADDR_CLEAN_WIN  = 5'h18;
  localparam logic [4:0]  ADDR_LOCK_COUNT = 5'h19;
  localparam logic [4:0]  ADDR_SYNTH_CFG  = 5'h1A;
  localparam logic [4:0]  ADDR_CLEAN_CFG  = 5'h1B;
  localparam logic [4:0]  ADDR_SYNTH_RDIV = 5'h1C;
  localparam int          CLEAN_WIN_LSB   = 6;
  localparam int          COUNT_LSB       = 6;
  localparam int          SWIN_LSB        = 30;
  localparam int          DOUBLER_BIT     = 29;
  localparam int          POL_BIT         = 28;
  localparam int          GAIN_LSB        = 26;
  localparam int          HIZ_BIT         = 5;
  localparam int          PRE2_LSB        = 24;
  localparam int          PRE1_LSB        = 22;
  localparam int          PRE0_LSB        = 20;
  localparam int          CRDIV_LSB       = 6;
  localparam int          SRDIV_LSB       = 20;
  localparam logic [1:0]  SWIN_VALID      = 2'h2;
  localparam logic [31:0] RST_CLEAN_WIN   = 32'h0000_0000;
  localparam logic [31:0] RST_LOCK_COUNT  = 32'h0000_0040;
  localparam logic [31:0] RST_SYNTH_CFG   = 32'h8000_0040;
  localparam logic [31:0] RST_CLEAN_CFG   = 32'h0000_0040;
  localparam logic [31:0] RST_SYNTH_RDIV  = 32'h0020_0000;
  localparam logic [15:0] CLEAN_WIN_PS [4] = '{16'h157C, 16'h2710, 16'h48A8, 16'h9C40};
  localparam logic [15:0] SYNTH_WIN_PS     = 16'h0E74;
  localparam logic [11:0] CLEAN_UA [4]     = '{12'h064, 12'h0C8, 12'h190, 12'h640};
  localparam logic [11:0] SYNTH_UA [4]     = '{12'h064, 12'h190, 12'h640, 12'hC80};
endpackage : dplcfg_pkg

//--- bench/dplcfg_host.sv
// Purpose: host controller model driving the serial configuration port
// Assumes: one 32-bit word per go pulse, first bit out is bit 31
// Notes: each bit holds the clock low one cycle and high one cycle
`timescale 1ns/1ns
module dplcfg_host (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        go_i,
  input  wire logic [31:0] word_i,
  output      logic        cfg_clk_o,
  output      logic        cfg_data_o,
  output      logic        cfg_latch_o,
  output      logic        busy_o
);
  logic [31:0] sh_reg;
  logic [6:0]  step_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_reg    <= 7'h00;
      busy_o      <= 1'b0;
      cfg_clk_o   <= 1'b0;
      cfg_latch_o <= 1'b0;
      cfg_data_o  <= 1'b0;
    end else if (go_i && !busy_o) begin
      sh_reg   <= word_i;
      step_reg <= 7'h00;
      busy_o   <= 1'b1;
    end else if (busy_o) begin
      step_reg <= step_reg + 7'h01;
      if (step_reg < 7'h40) begin
        cfg_clk_o <= step_reg[0];
        if (!step_reg[0]) begin
          cfg_data_o <= sh_reg[31];
        end else begin
          sh_reg <= sh_reg << 1;
        end
      end else if (step_reg == 7'h40) begin
        cfg_clk_o   <= 1'b0;
        cfg_latch_o <= 1'b1;
        // data line released: show the inverse so a stale bit is never trusted
        cfg_data_o  <= ~cfg_data_o;
      end else begin
        cfg_latch_o <= 1'b0;
        busy_o      <= 1'b0;
      end
    end
  end
endmodule : dplcfg_host

//--- bench/dplcfg_top_tb.sv
// Purpose: self-checking bench for the dual-loop lock and divider block
// Assumes: host model writes every register through the serial port
// Notes: each scenario task after t_reset drives the block and judges its own results
`timescale 1ns/1ns
module dplcfg_top_tb;
  import dplcfg_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, go = 1'b0, cc, cd, cl, busy;
  logic [31:0] word = 32'h0;
  logic        ccmp = 1'b0, scmp = 1'b0, orise = 1'b0, ofall = 1'b0;
  logic [15:0] cerr = 16'h0, serr = 16'h0;
  logic [2:0]  edg = 3'h0;
  logic [1:0]  act = 2'h0;
  logic        clk_lk, syn_lk, cref, sref, chiz, cpol, shiz, spol, dbl;
  logic [11:0] cua, sua;
  int          fail_count = 0, n_compared = 0, cpn = 0, spn = 0;

  dplcfg_host dplcfg_host_inst (.clk_i(clk), .rst_i(rst), .go_i(go), .word_i(word),
    .cfg_clk_o(cc), .cfg_data_o(cd), .cfg_latch_o(cl), .busy_o(busy));
  dplcfg_top dplcfg_top_inst (.ref_clk_i(clk), .rst_i(rst), .cfg_clk_i(cc),
    .cfg_data_i(cd), .cfg_latch_i(cl), .clean_cmp_i(ccmp), .clean_phase_err_i(cerr),
    .synth_cmp_i(scmp), .synth_phase_err_i(serr), .input_edge_i(edg),
    .active_input_i(act), .osc_rise_i(orise), .osc_fall_i(ofall),
    .cleaning_lock_o(clk_lk), .synthesis_lock_o(syn_lk), .cleaning_pd_ref_o(cref),
    .synthesis_pd_ref_o(sref), .cleaning_pump_current_o(cua),
    .cleaning_pump_hiz_o(chiz), .cleaning_pump_polarity_o(cpol),
    .synthesis_pump_current_o(sua), .synthesis_pump_hiz_o(shiz),
    .synthesis_pump_polarity_o(spol), .ref_doubler_enable_o(dbl));

  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cref === 1'b1) cpn++;
    if (sref === 1'b1) spn++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [31:0] w);
    word = w;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    for (int i = 0; i < 100 && busy; i++) tick(1);
    tick(2);
  endtask : wr
  // synthesis window always code 2, the only legal setting
  function automatic logic [31:0] sw(input logic d, p, input logic [1:0] g,
                                     input logic [13:0] n, input logic h);
    return {2'h2, d, p, g, 6'h00, n, h, ADDR_SYNTH_CFG};
  endfunction : sw
  function automatic logic [31:0] cw(input logic p, input logic [1:0] g,
                                     input logic [5:0] pr, input logic [13:0] r, input logic h);
    return {3'h0, p, g, pr, r, h, ADDR_CLEAN_CFG};
  endfunction : cw
  task automatic cmp(input logic s, input int e, input logic exp);
    ccmp = !s;
    scmp = s;
    cerr = 16'(e);
    serr = 16'(e);
    tick(1);
    chk(s ? syn_lk : clk_lk, exp);
    ccmp = 1'b0;
    scmp = 1'b0;
    tick(1);
  endtask : cmp

  task automatic t_reset;
    chk(cua, 12'h064);
    chk(sua, 12'h064);
    chk({chiz, shiz, cpol, spol, dbl}, 5'h00);
  endtask : t_reset
  task automatic t_pump;
    int su[4] = '{100, 400, 1600, 3200};
    int cu[4] = '{100, 200, 400, 1600};
    for (int g = 0; g < 4; g++) begin
      wr(sw(1'b0, g[0], g[1:0], 14'h1, 1'b0));
      chk(sua, su[g]);
      chk(spol, g[0]);
      wr(cw(g[0], g[1:0], 6'h00, 14'h1, 1'b0));
      chk(cua, cu[g]);
      chk(cpol, g[0]);
    end
    wr(sw(1'b0, 1'b0, 2'h3, 14'h1, 1'b1));
    chk({shiz, sua}, 13'h1000);
    wr(cw(1'b0, 2'h3, 6'h00, 14'h1, 1'b1));
    chk({chiz, cua}, 13'h1000);
  endtask : t_pump
  task automatic t_clean_lock;
    int w[4] = '{5500, 10000, 18600, 40000};
    wr({12'h000, 14'h0003, 1'b0, ADDR_LOCK_COUNT});
    for (int c = 0; c < 4; c++) begin
      wr({24'h0, c[1:0], 1'b0, ADDR_CLEAN_WIN});
      cmp(1'b0, w[c], 1'b0);
      repeat (2) cmp(1'b0, w[c] - 1, 1'b0);
      cmp(1'b0, w[c] - 1, 1'b1);
      cmp(1'b0, w[c], 1'b0);
    end
  endtask : t_clean_lock
  task automatic t_synth_lock;
    wr(sw(1'b0, 1'b0, 2'h0, 14'h2, 1'b0));
    cmp(1'b1, 3700, 1'b0);
    cmp(1'b1, 3699, 1'b0);
    cmp(1'b1, 3699, 1'b1);
    cmp(1'b1, 3700, 1'b0);
    wr(sw(1'b0, 1'b0, 2'h0, 14'h0, 1'b0));
    repeat (3) cmp(1'b1, 3699, 1'b0);
  endtask : t_synth_lock
  task automatic t_clean_div;
    int pre[3] = '{1, 2, 8};
    int base;
    wr(cw(1'b0, 2'h0, {2'h3, 2'h1, 2'h0}, 14'h3, 1'b0));
    for (int s = 0; s < 3; s++) begin
      act = 2'(s);
      tick(2);
      base = cpn;
      // unselected inputs pulse twice as often and must be ignored
      repeat (6 * pre[s]) begin
        edg = ~(3'h1 << s);
        tick(1);
        edg = 3'h7;
        tick(1);
      end
      edg = 3'h0;
      tick(4);
      chk(cpn - base, 2);
    end
  endtask : t_clean_div
  task automatic t_synth_div;
    int base;
    for (int d = 0; d < 2; d++) begin
      // doubler set before a divide of 1 is ever programmed
      wr(sw(d[0], 1'b0, 2'h0, 14'h1, 1'b0));
      wr({12'(2 - d), 15'h0, ADDR_SYNTH_RDIV});
      chk(dbl, d[0]);
      base = spn;
      repeat (4) begin
        orise = 1'b1;
        tick(1);
        orise = 1'b0;
        ofall = 1'b1;
        tick(1);
        ofall = 1'b0;
      end
      tick(4);
      chk(spn - base, d ? 8 : 2);
    end
  endtask : t_synth_div

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(2);
    t_reset;
    t_pump;
    t_clean_lock;
    t_synth_lock;
    t_clean_div;
    t_synth_div;
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test;
  end
endmodule : dplcfg_top_tb
